/* periph_clock_gate.v */
`timescale 1ns/1ps
`include "clock_gate_defines.vh"

// What this block does
// - a set gate bit clocks its peripheral; a clear bit leaves it unclocked
// - any access to an unclocked peripheral is answered with a bus fault
// - all gate bits read zero after reset; every peripheral starts unclocked
// - run register in run mode, sleep register asleep, deep register in deep sleep
// - sleep and deep registers only act when automatic gating is selected
// - deep sleep gate register at offset 0x124, 32 bits, resets to zero
// - bits 18, 17, 16 gate timers two, one and zero
// - bit 4 gates synchronous serial port zero
// - bits 1 and 0 gate asynchronous serial ports one and zero
// - reserved bits are read-only zero; software preserves them
// - bits 26, 25, 24 gate comparators two, one and zero

module periph_clock_gate #(
    parameter ADDR_W = 12
) (
    input  wire                     CORE_CLK,
    input  wire                     RESET,
    input  wire                     WB_CYC_I,
    input  wire                     WB_STB_I,
    input  wire                     WB_WE_I,
    input  wire [ADDR_W-1:0]        WB_ADR_I,
    input  wire [3:0]               WB_SEL_I,
    input  wire [31:0]              WB_DAT_I,
    output reg  [31:0]              WB_DAT_O,
    output reg                      WB_ACK_O,
    input  wire                     SLEEP_REQ,
    input  wire                     DEEP_SLEEP_REQ,
    input  wire                     PERIPH_REQ,
    input  wire [3:0]               PERIPH_SEL,
    output wire                     PERIPH_FAULT,
    output wire                     PERIPH_GRANT,
    output wire [`PERIPH_COUNT-1:0] PERIPH_CLK_EN,
    output wire [1:0]               POWER_MODE,
    output wire                     IRQ
);

    // ==========================================
    // registers
    reg [31:0]             run_gate_reg_one_r;
    reg [31:0]             sleep_gate_reg_one_r;
    reg [31:0]             deep_sleep_gate_reg_one_r;
    reg [31:0]             run_clock_config_reg_r;
    reg [`EVT_COUNT-1:0]   irq_status_r;
    reg [`EVT_COUNT-1:0]   irq_enable_r;
    reg [1:0]              mode_r;
    reg [1:0]              mode_nxt;
    reg [31:0]             rd_nxt;

    wire                   bus_req;
    wire                   wr_en;
    wire [31:0]            byte_mask;
    wire                   fault_evt;
    wire                   mode_evt;
    wire [`EVT_COUNT-1:0]  evt_set;
    wire [`EVT_COUNT-1:0]  evt_clr;
    wire                   auto_gating_select;

    // ==========================================
    // bus decode
    assign bus_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr_en     = bus_req & WB_WE_I;
    assign byte_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    assign auto_gating_select = run_clock_config_reg_r[`AUTO_GATE_BIT];

    // writable lanes only; reserved bits never store a one
    function [31:0] merge_gate;
        input [31:0] old_val;
        input [31:0] new_val;
        input [31:0] lanes;
        begin
            merge_gate = ((old_val & ~lanes) | (new_val & lanes)) & `GATE_WMASK;
        end
    endfunction

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            run_gate_reg_one_r        <= `GATE_RESET;
            sleep_gate_reg_one_r      <= `GATE_RESET;
            deep_sleep_gate_reg_one_r <= `GATE_RESET;
            run_clock_config_reg_r    <= `RUN_CFG_RESET;
            irq_enable_r              <= {`EVT_COUNT{1'b0}};
        end else if (wr_en) begin
            case (WB_ADR_I)
                `RUN_GATE_OFS: begin
                    run_gate_reg_one_r <= merge_gate(run_gate_reg_one_r, WB_DAT_I, byte_mask);
                end
                `SLEEP_GATE_OFS: begin
                    sleep_gate_reg_one_r <= merge_gate(sleep_gate_reg_one_r, WB_DAT_I, byte_mask);
                end
                `DEEP_GATE_OFS: begin
                    deep_sleep_gate_reg_one_r <= merge_gate(deep_sleep_gate_reg_one_r, WB_DAT_I, byte_mask);
                end
                `RUN_CFG_OFS: begin
                    if (WB_SEL_I[0]) begin
                        run_clock_config_reg_r[`AUTO_GATE_BIT] <= WB_DAT_I[`AUTO_GATE_BIT];
                    end
                end
                `IRQ_ENABLE_OFS: begin
                    if (WB_SEL_I[0]) begin
                        irq_enable_r <= WB_DAT_I[`EVT_COUNT-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // read mux
    always @* begin
        rd_nxt = 32'h00000000;
        case (WB_ADR_I)
            `RUN_GATE_OFS:   rd_nxt = run_gate_reg_one_r;
            `SLEEP_GATE_OFS: rd_nxt = sleep_gate_reg_one_r;
            `DEEP_GATE_OFS:  rd_nxt = deep_sleep_gate_reg_one_r;
            `RUN_CFG_OFS:    rd_nxt = run_clock_config_reg_r;
            `IRQ_STATUS_OFS: rd_nxt = {30'h00000000, irq_status_r};
            `IRQ_ENABLE_OFS: rd_nxt = {30'h00000000, irq_enable_r};
            default:         rd_nxt = 32'h00000000;
        endcase
    end

    // one wait state; unmapped addresses read zero and drop writes
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_req & ~WB_WE_I) begin
                WB_DAT_O <= rd_nxt;
            end
        end
    end

    // ==========================================
    // power mode tracking
    always @* begin
        mode_nxt = `MODE_RUN;
        if (DEEP_SLEEP_REQ) begin
            mode_nxt = `MODE_DEEP;
        end else if (SLEEP_REQ) begin
            mode_nxt = `MODE_SLEEP;
        end
    end

    always @(posedge CORE_CLK) begin
        if (RESET) begin
            mode_r <= `MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    assign mode_evt   = (mode_r != mode_nxt);
    assign POWER_MODE = mode_r;

    // ==========================================
    // gate selection and access check
    gate_select u_gate_select (
        .clk         (CORE_CLK),
        .reset       (RESET),
        .mode        (mode_r),
        .auto_gate   (auto_gating_select),
        .run_gates   (run_gate_reg_one_r),
        .sleep_gates (sleep_gate_reg_one_r),
        .deep_gates  (deep_sleep_gate_reg_one_r),
        .clk_en_r    (PERIPH_CLK_EN)
    );

    fault_check u_fault_check (
        .clk         (CORE_CLK),
        .reset       (RESET),
        .req         (PERIPH_REQ),
        .sel         (PERIPH_SEL),
        .clk_en      (PERIPH_CLK_EN),
        .fault       (PERIPH_FAULT),
        .grant       (PERIPH_GRANT),
        .fault_evt_r (fault_evt)
    );

    // ==========================================
    // interrupts
    assign evt_set = {mode_evt, fault_evt};
    assign evt_clr = (wr_en && (WB_ADR_I == `IRQ_CLEAR_OFS) && WB_SEL_I[0]) ?
                     WB_DAT_I[`EVT_COUNT-1:0] : {`EVT_COUNT{1'b0}};

    // a new event beats a clear landing in the same cycle
    always @(posedge CORE_CLK) begin
        if (RESET) begin
            irq_status_r <= {`EVT_COUNT{1'b0}};
        end else begin
            irq_status_r <= (irq_status_r & ~evt_clr) | evt_set;
        end
    end

    assign IRQ = |(irq_status_r & irq_enable_r);

endmodule // periph_clock_gate

/* clock_gate_defines.vh */
`ifndef CLOCK_GATE_DEFINES_VH
`define CLOCK_GATE_DEFINES_VH

// ==========================================
// register byte offsets
`define RUN_GATE_OFS        12'h104
`define SLEEP_GATE_OFS      12'h114
`define DEEP_GATE_OFS       12'h124
`define RUN_CFG_OFS         12'h060
`define IRQ_STATUS_OFS      12'h200
`define IRQ_ENABLE_OFS      12'h204
`define IRQ_CLEAR_OFS       12'h208

// ==========================================
// gating register layout
`define GATE_RESET          32'h00000000
`define GATE_WMASK          32'h07070013
`define ASYNC_ZERO_BIT      0
`define ASYNC_ONE_BIT       1
`define SYNC_ZERO_BIT       4
`define TIMER_ZERO_BIT      16
`define TIMER_ONE_BIT       17
`define TIMER_TWO_BIT       18
`define COMP_ZERO_BIT       24
`define COMP_ONE_BIT        25
`define COMP_TWO_BIT        26

// ==========================================
// run clock configuration and interrupts
`define RUN_CFG_RESET       32'h00000000
`define AUTO_GATE_BIT       0
`define EVT_FAULT_BIT       0
`define EVT_MODE_BIT        1
`define EVT_COUNT           2

// ==========================================
// power modes and peripheral count
`define MODE_RUN            2'h0
`define MODE_SLEEP          2'h1
`define MODE_DEEP           2'h2
`define PERIPH_COUNT        9

`endif

/* gate_select.v */
`timescale 1ns/1ps
`include "clock_gate_defines.vh"

module gate_select (
    input  wire                     clk,
    input  wire                     reset,
    input  wire [1:0]               mode,
    input  wire                     auto_gate,
    input  wire [31:0]              run_gates,
    input  wire [31:0]              sleep_gates,
    input  wire [31:0]              deep_gates,
    output reg  [`PERIPH_COUNT-1:0] clk_en_r
);

    // ==========================================
    // gate vector compaction
    function [`PERIPH_COUNT-1:0] compact;
        input [31:0] g;
        begin
            compact = {g[`COMP_TWO_BIT], g[`COMP_ONE_BIT], g[`COMP_ZERO_BIT],
                       g[`TIMER_TWO_BIT], g[`TIMER_ONE_BIT], g[`TIMER_ZERO_BIT],
                       g[`SYNC_ZERO_BIT],
                       g[`ASYNC_ONE_BIT], g[`ASYNC_ZERO_BIT]};
        end
    endfunction

    // ==========================================
    // mode selection
    reg [`PERIPH_COUNT-1:0] clk_en_nxt;

    always @* begin
        clk_en_nxt = compact(run_gates);
        if (auto_gate) begin
            case (mode)
                `MODE_SLEEP: clk_en_nxt = compact(sleep_gates);
                `MODE_DEEP:  clk_en_nxt = compact(deep_gates);
                default:     clk_en_nxt = compact(run_gates);
            endcase
        end
    end

    // registered so the enables only move on a clock edge, never glitch
    always @(posedge clk) begin
        if (reset) begin
            clk_en_r <= {`PERIPH_COUNT{1'b0}};
        end else begin
            clk_en_r <= clk_en_nxt;
        end
    end

endmodule // gate_select

/* fault_check.v */
`timescale 1ns/1ps
`include "clock_gate_defines.vh"

module fault_check (
    input  wire                     clk,
    input  wire                     reset,
    input  wire                     req,
    input  wire [3:0]               sel,
    input  wire [`PERIPH_COUNT-1:0] clk_en,
    output wire                     fault,
    output wire                     grant,
    output reg                      fault_evt_r
);

    // ==========================================
    // access check
    wire sel_valid;
    wire sel_clocked;

    assign sel_valid   = (sel < 4'h9);
    // out-of-range index counts as unclocked: nothing answers there
    assign sel_clocked = sel_valid & clk_en[sel];
    assign fault       = req & ~sel_clocked;
    assign grant       = req & sel_clocked;

    always @(posedge clk) begin
        if (reset) begin
            fault_evt_r <= 1'b0;
        end else begin
            fault_evt_r <= fault;
        end
    end

endmodule // fault_check

/* clock_gate_asserts.sv */
`timescale 1ns/1ps
`include "clock_gate_defines.vh"
// ==========================================
// port checker
module clock_gate_asserts (
    input wire                     CORE_CLK,
    input wire                     RESET,
    input wire                     WB_CYC_I,
    input wire                     WB_STB_I,
    input wire                     WB_WE_I,
    input wire                     WB_ACK_O,
    input wire                     SLEEP_REQ,
    input wire                     DEEP_SLEEP_REQ,
    input wire                     PERIPH_REQ,
    input wire [3:0]               PERIPH_SEL,
    input wire                     PERIPH_FAULT,
    input wire                     PERIPH_GRANT,
    input wire [`PERIPH_COUNT-1:0] PERIPH_CLK_EN,
    input wire [1:0]               POWER_MODE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    sequence wb_taken;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence ack_once;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    ack_answer_a: assert property (wb_taken |=> ack_once) else $error("ack late or stretched");
    fault_map_a: assert property (
        PERIPH_REQ && PERIPH_SEL < 4'h9 |-> PERIPH_FAULT != PERIPH_CLK_EN[PERIPH_SEL]) else $error("fault map");
    fault_range_a: assert property (
        PERIPH_REQ && PERIPH_SEL > 4'h8 |-> PERIPH_FAULT) else $error("bad index granted");
    grant_rule_a: assert property (PERIPH_REQ |-> PERIPH_GRANT != PERIPH_FAULT) else $error("grant");
    reset_clear_a: assert property (
        $fell(RESET) |-> PERIPH_CLK_EN == 9'h000 && POWER_MODE == 2'h0) else $error("reset state");
    deep_mode_a: assert property (DEEP_SLEEP_REQ |=> POWER_MODE == 2'h2) else $error("deep mode");
    sleep_mode_a: assert property (
        SLEEP_REQ && !DEEP_SLEEP_REQ |=> POWER_MODE == 2'h1) else $error("sleep mode");
    // enables move only a cycle after a register write or a mode step
    clk_en_cause_a: assert property ($changed(PERIPH_CLK_EN) |-> $past(WB_ACK_O && WB_WE_I) ||
        $past(POWER_MODE) != $past(POWER_MODE, 2)) else $error("enable moved alone");
endmodule // clock_gate_asserts

bind periph_clock_gate clock_gate_asserts i_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ACK_O(WB_ACK_O), .SLEEP_REQ(SLEEP_REQ),
    .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .PERIPH_REQ(PERIPH_REQ), .PERIPH_SEL(PERIPH_SEL),
    .PERIPH_FAULT(PERIPH_FAULT), .PERIPH_GRANT(PERIPH_GRANT), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .POWER_MODE(POWER_MODE));

/* periph_master.sv */
`timescale 1ns/1ps
// ==========================================
// peripheral access master
module periph_master (
    input  wire        clk,
    input  wire        rst,
    input  wire        go,
    input  wire  [3:0] idx,
    input  wire        fault,
    output logic       req = 1'b0,
    output logic [3:0] sel = 4'h0,
    output logic       faulted,
    output logic       done
);
    // idle select toggles so a stale index never holds steady; it returns every other cycle
    always @(posedge clk) begin
        done <= 1'b0;
        sel <= ~sel;
        if (rst) begin
            req <= 1'b0;
        end else if (req) begin
            faulted <= fault;
            done <= 1'b1;
            req <= 1'b0;
        end else if (go) begin
            req <= 1'b1;
            sel <= idx;
        end
    end
endmodule // periph_master

/* test_periph_clock_gate.sv */
`timescale 1ns/1ps
`include "clock_gate_defines.vh"
// ==========================================
// bench top
module test_periph_clock_gate;
    typedef struct { logic [31:0] w, r; logic [8:0] e; } row_t;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slp = 0, deep = 0, go = 0;
    logic [11:0] adr = 0;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic [3:0]  idx = 0, psel;
    logic        ack, preq, fault, irq, faulted, pdone;
    logic [8:0]  en;
    logic [1:0]  mode;
    int          miscompares = 0, check_count = 0;
    row_t rows[6] = '{'{32'h00000001, 32'h00000001, 9'h001}, '{32'h00000012, 32'h00000012, 9'h006},
        '{32'h00070000, 32'h00070000, 9'h038}, '{32'h07000000, 32'h07000000, 9'h1C0},
        '{32'hFFFFFFFF, 32'h07070013, 9'h1FF}, '{32'hF8F8FFEC, 32'h00000000, 9'h000}};
    always #2 clk = ~clk;
    periph_clock_gate i_dut (.CORE_CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .SLEEP_REQ(slp), .DEEP_SLEEP_REQ(deep), .PERIPH_REQ(preq), .PERIPH_SEL(psel),
        .PERIPH_FAULT(fault), .PERIPH_GRANT(), .PERIPH_CLK_EN(en), .POWER_MODE(mode), .IRQ(irq));
    periph_master i_far (.clk(clk), .rst(rst), .go(go), .idx(idx), .fault(fault), .req(preq),
        .sel(psel), .faulted(faulted), .done(pdone));
    // ==========================================
    // tasks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        for (n = 0; n < 16 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 16) begin
            miscompares++;
            tally_and_finish;
        end
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic access(input logic [3:0] i);
        int n;
        @(posedge clk);
        {go, idx} <= {1'b1, i};
        @(posedge clk);
        go <= 1'b0;
        for (n = 0; n < 8 && pdone !== 1'b1; n++) @(posedge clk);
        if (n == 8) begin
            miscompares++;
            tally_and_finish;
        end
    endtask
    // mode pins settle into the enables two edges later
    task automatic set_mode(input logic s, input logic d, input logic [8:0] e, input logic [1:0] m);
        @(posedge clk);
        {slp, deep} <= {s, d};
        repeat (3) @(posedge clk);
        chk_reg({23'h0, en}, {23'h0, e});
        chk_reg({30'h0, mode}, {30'h0, m});
    endtask
    // ==========================================
    // sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb(0, `DEEP_GATE_OFS, 0);
        chk_reg(rdat, `GATE_RESET);
        chk_reg({23'h0, en}, 0);
        $display("reset test done");
        foreach (rows[r]) begin
            wb(1, `RUN_GATE_OFS, rows[r].w);
            wb(0, `RUN_GATE_OFS, 0);
            chk_reg(rdat, rows[r].r);
            chk_reg({23'h0, en}, {23'h0, rows[r].e});
            for (int i = 0; i < 10; i++) begin
                access(i[3:0]);
                chk_bit(faulted, i > 8 ? 1'b1 : !rows[r].e[i]);
            end
            $display("row %0d done", r);
        end
        wb(1, `RUN_GATE_OFS, 32'h1);
        wb(1, `SLEEP_GATE_OFS, 32'h10);
        wb(1, `DEEP_GATE_OFS, 32'h00070000);
        wb(1, `IRQ_CLEAR_OFS, 32'h3);
        wb(1, `IRQ_ENABLE_OFS, 32'h2);
        set_mode(1, 0, 9'h001, 2'h1);
        wb(1, `RUN_CFG_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk_reg({23'h0, en}, 32'h004);
        set_mode(1, 1, 9'h038, 2'h2);
        set_mode(0, 0, 9'h001, 2'h0);
        chk_bit(irq, 1);
        wb(1, `IRQ_CLEAR_OFS, 32'h3);
        wb(1, `IRQ_ENABLE_OFS, 32'h0);
        access(4'hA);
        chk_bit(faulted, 1);
        wb(0, `IRQ_STATUS_OFS, 0);
        chk_reg(rdat, 32'h1);
        chk_bit(irq, 0);
        wb(1, `IRQ_ENABLE_OFS, 32'h1);
        chk_bit(irq, 1);
        wb(1, `IRQ_CLEAR_OFS, 32'h1);
        chk_bit(irq, 0);
        wb(1, 12'h300, 32'hFFFFFFFF);
        wb(0, 12'h300, 0);
        chk_reg(rdat, 0);
        $display("mode and irq test done");
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb(0, `SLEEP_GATE_OFS, 0);
        chk_reg(rdat, `GATE_RESET);
        chk_reg({23'h0, en}, 0);
        $display("second reset test done");
        tally_and_finish;
    end
endmodule // test_periph_clock_gate
